// ===== shared/orsm_pkg.sv
// Purpose: constants and types for the on-chip ram and register map
// Assumes: apb word per location, byte address = index * 4
// Notes:   register slots follow the sfr address table order
package orsm_pkg;
    localparam int RAM_DEPTH = 128;
    localparam int SFR_COUNT = 20;
    // sfr byte addresses, slot 0 last
    localparam logic [SFR_COUNT-1:0][7:0] SFR_ADDR = {
        8'hf0, 8'he0, 8'hd0, 8'hb8, 8'hb0, 8'ha8, 8'ha0, 8'h99, 8'h98,
        8'h90, 8'h8d, 8'h8c, 8'h8b, 8'h8a, 8'h89, 8'h88, 8'h83, 8'h82,
        8'h81, 8'h80};
    localparam logic [4:0] SLOT_PUSH_PTR = 5'h01;
    localparam logic [4:0] SLOT_EXT_LOW = 5'h02;
    localparam logic [4:0] SLOT_EXT_HIGH = 5'h03;
    localparam logic [4:0] SLOT_CTRL = 5'h04;
    localparam logic [4:0] SLOT_C0_LOW = 5'h06;
    localparam logic [4:0] SLOT_C1_LOW = 5'h07;
    localparam logic [4:0] SLOT_C0_HIGH = 5'h08;
    localparam logic [4:0] SLOT_C1_HIGH = 5'h09;
    localparam logic [4:0] SLOT_PORT1 = 5'h0a;
    localparam logic [4:0] SLOT_PORT3 = 5'h0f;
    localparam logic [4:0] SLOT_FLAGS = 5'h11;
    localparam logic [7:0] PUSH_PTR_RESET = 8'h07;
    localparam logic [7:0] SFR_RESET = 8'h00;
    localparam logic [7:0] PORT3_RSV_MASK = 8'hc4;
    // counter control and flags bank bit positions
    localparam int CTRL_RUN0 = 4;
    localparam int CTRL_OVF0 = 5;
    localparam int CTRL_RUN1 = 6;
    localparam int CTRL_OVF1 = 7;
    localparam int FLAGS_BANK_LSB = 3;
    // word index map (byte address = index * 4)
    localparam logic [9:0] IDX_SFR_BASE = 10'h080;
    localparam logic [9:0] IDX_BIT_BASE = 10'h100;
    localparam logic [9:0] IDX_WIDE_EXT = 10'h200;
    localparam logic [9:0] IDX_WIDE_C0 = 10'h201;
    localparam logic [9:0] IDX_WIDE_C1 = 10'h202;
    localparam logic [7:0] BIT_RAM_BYTE_BASE = 8'h20;
    localparam logic [7:0] BIT_SFR_LAST = 8'hf7;
    localparam logic [7:0] UNASSIGNED_READ = 8'h00;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int STOP_TIME_US = 500;
    localparam int STOP_CYCLES = STOP_TIME_US * CLK_MHZ;
    localparam int TICK_DIV = 12;

    typedef enum logic [1:0] {
        ST_IDLE, ST_RD, ST_RMW, ST_DONE
    } orsm_st_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } orsm_apb_req_t;

    typedef struct packed {
        logic [15:0] ext_pointer;
        logic [15:0] counter_zero_value;
        logic [15:0] counter_one_value;
        logic [7:0] push_pointer;
        logic [6:0] bank_base;
    } orsm_view_t;

    typedef struct packed {
        orsm_st_t st;
        logic [SFR_COUNT-1:0][7:0] sfr;
        logic [7:0] port1_pins;
        logic [7:0] port3_pins;
        logic [7:0] tick_cnt;
        logic [16:0] stop_cnt;
        logic stopping;
        logic halted;
        logic err;
        logic is_bit;
        logic [2:0] bit_pos;
        logic bit_val;
        logic [31:0] rdata;
    } orsm_state_t;
endpackage : orsm_pkg

// ===== design/orsm_ram.sv
// Purpose: single port byte ram with registered read data
// Assumes: one access per cycle, write has no read return
// Notes:   no reset on contents, as with real on-chip ram
`timescale 1ns/10ps
module orsm_ram #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8
) (
    // clock
    input wire logic pclk,
    // access
    input wire logic en,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // store on write, latch read data on an enabled read
    always_ff @(posedge pclk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end else if (en) begin
            rdata <= mem[addr];
        end
    end
endmodule : orsm_ram

// ===== design/orsm_top.sv
// Purpose: data ram, sfr file, bit space and kit port handling
// Assumes: apb3 slave, inputs synchronous to pclk
// Notes:   core pushes take priority over apb accesses
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module orsm_top
    import orsm_pkg::*;
#(
    parameter int STOP_COUNT = STOP_CYCLES,
    parameter int TICK_COUNT = TICK_DIV
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core stack push
    input wire logic push_valid,
    input wire logic [7:0] push_data,
    output logic push_ready,
    // kit execution control
    input wire logic exec_start,
    input wire logic break_event,
    output logic timers_halted,
    // user port pins
    output logic [7:0] port1_pins,
    output logic [7:0] port3_pins,
    // register views
    output orsm_view_t view
);
    orsm_state_t s;
    orsm_state_t next_s;
    orsm_apb_req_t req;
    logic ram_en;
    logic ram_we;
    logic [6:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;

    // address map seen from the bus, as word indices:
    //   000-07f  data ram, one byte per word, bits 7:0
    //   080-0ff  special function registers, sparse
    //   100-1ff  bit space, index minus 100 is the bit address
    //   200      external pointer as one 16-bit word
    //   201      counter zero as one 16-bit word
    //   202      counter one as one 16-bit word
    //   others   refused with pslverr
    // bit addresses below 80 pick bits of ram bytes 20-2f;
    // from 80 up they pick bits of the sfr whose address is
    // the bit address with its low three bits cleared, so
    // only sfrs at multiples of eight are bit addressable.
    // bit addresses f8-ff read zero and drop writes.
    //
    // timing of an access, counted from the taking edge:
    //   sfr, bit sfr, wide view, ram write: one cycle
    //   ram read and ram bit read: two cycles
    //   ram bit write: two cycles, read then write back
    // pready is high for exactly one cycle per access.
    //
    // a core push owns the idle slot; while push_valid is
    // held, bus accesses wait. the core must leave gaps,
    // there is no starvation guard on the bus side.
    //
    // the ram has a single port, so a bit write to ram
    // cannot finish in one cycle; the rmw state holds the
    // old byte for one cycle and writes it back merged.
    //
    // flags, counters and pointer all live in the sfr array
    // so byte, bit and wide views share one copy and a
    // wide write can never be seen half done.
    //
    // counters advance once per divided tick, never on the
    // fast clock, and only while their run bit is set and
    // the halt after a break has not yet taken effect.

    orsm_ram #(
        .DEPTH(RAM_DEPTH),
        .WIDTH(8)
    ) u_ram (
        .pclk(pclk),
        .en(ram_en),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(ram_wdata),
        .rdata(ram_rdata)
    );

    // slot lookup: bit 5 says the address is an assigned sfr
    // the table is small, so a linear search costs little
    function automatic logic [5:0] sfr_slot(input logic [7:0] a);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < SFR_COUNT; i++) begin
            if (SFR_ADDR[i] == a) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction : sfr_slot

    assign req = '{psel, penable, pwrite, paddr, pwdata};

    // next state: pushes, apb decode, ports, counters
    always_comb begin
        logic [9:0] idx;
        logic [7:0] bit_addr;
        logic [7:0] bit_byte;
        logic [5:0] slot;
        logic [16:0] c0;
        logic [16:0] c1;
        logic tick;
        idx = req.paddr[11:2];
        bit_addr = idx[7:0];
        bit_byte = 8'h00;
        slot = 6'h00;
        c0 = 17'h00000;
        c1 = 17'h00000;
        tick = 1'b0;
        next_s = s;
        ram_en = 1'b0;
        ram_we = 1'b0;
        ram_addr = 7'h00;
        ram_wdata = 8'h00;

        case (s.st)
            ST_IDLE: begin
                if (push_valid) begin
                    next_s.sfr[SLOT_PUSH_PTR] = s.sfr[SLOT_PUSH_PTR] + 8'h01;
                    ram_en = 1'b1;
                    ram_we = 1'b1;
                    ram_addr = 7'(s.sfr[SLOT_PUSH_PTR] + 8'h01);
                    ram_wdata = push_data;
                end else if (req.psel && req.penable) begin
                    next_s.err = 1'b0;
                    next_s.is_bit = 1'b0;
                    next_s.rdata = 32'h00000000;
                    next_s.st = ST_DONE;
                    if (idx < IDX_SFR_BASE) begin
                        ram_en = 1'b1;
                        ram_we = req.pwrite;
                        ram_addr = idx[6:0];
                        ram_wdata = req.pwdata[7:0];
                        if (!req.pwrite) begin
                            next_s.st = ST_RD;
                        end
                    end else if (idx < IDX_BIT_BASE) begin
                        slot = sfr_slot(idx[7:0]);
                        if (req.pwrite && slot[5]) begin
                            next_s.sfr[slot[4:0]] = req.pwdata[7:0];
                        end
                        next_s.rdata[7:0] = slot[5] ? s.sfr[slot[4:0]]
                                                    : UNASSIGNED_READ;
                    end else if (idx < IDX_WIDE_EXT) begin
                        next_s.bit_pos = bit_addr[2:0];
                        next_s.bit_val = req.pwdata[0];
                        next_s.is_bit = 1'b1;
                        if (!bit_addr[7]) begin
                            ram_en = 1'b1;
                            ram_addr = 7'(BIT_RAM_BYTE_BASE + 8'(bit_addr[6:3]));
                            next_s.st = req.pwrite ? ST_RMW : ST_RD;
                        end else begin
                            bit_byte = {bit_addr[7:3], 3'b000};
                            slot = sfr_slot(bit_byte);
                            if (bit_addr <= BIT_SFR_LAST && slot[5]) begin
                                if (req.pwrite) begin
                                    next_s.sfr[slot[4:0]][bit_addr[2:0]] =
                                        req.pwdata[0];
                                end
                                next_s.rdata[0] =
                                    s.sfr[slot[4:0]][bit_addr[2:0]];
                            end
                        end
                    end else if (idx == IDX_WIDE_EXT) begin
                        if (req.pwrite) begin
                            next_s.sfr[SLOT_EXT_LOW] = req.pwdata[7:0];
                            next_s.sfr[SLOT_EXT_HIGH] = req.pwdata[15:8];
                        end
                        next_s.rdata[15:0] = {s.sfr[SLOT_EXT_HIGH],
                                              s.sfr[SLOT_EXT_LOW]};
                    end else if (idx == IDX_WIDE_C0) begin
                        if (req.pwrite) begin
                            next_s.sfr[SLOT_C0_LOW] = req.pwdata[7:0];
                            next_s.sfr[SLOT_C0_HIGH] = req.pwdata[15:8];
                        end
                        next_s.rdata[15:0] = {s.sfr[SLOT_C0_HIGH],
                                              s.sfr[SLOT_C0_LOW]};
                    end else if (idx == IDX_WIDE_C1) begin
                        if (req.pwrite) begin
                            next_s.sfr[SLOT_C1_LOW] = req.pwdata[7:0];
                            next_s.sfr[SLOT_C1_HIGH] = req.pwdata[15:8];
                        end
                        next_s.rdata[15:0] = {s.sfr[SLOT_C1_HIGH],
                                              s.sfr[SLOT_C1_LOW]};
                    end else begin
                        next_s.err = 1'b1;  // outside every region
                    end
                end
            end
            ST_RD: begin
                // ram data is valid one cycle after the read strobe
                next_s.rdata[7:0] = s.is_bit ? {7'h00, ram_rdata[s.bit_pos]}
                                             : ram_rdata;
                next_s.st = ST_DONE;
            end
            ST_RMW: begin
                ram_en = 1'b1;
                ram_we = 1'b1;
                ram_addr = 7'(BIT_RAM_BYTE_BASE + 8'(bit_addr[6:3]));
                ram_wdata = ram_rdata;
                ram_wdata[s.bit_pos] = s.bit_val;
                next_s.st = ST_DONE;
            end
            ST_DONE: begin
                next_s.st = ST_IDLE;
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase

        // a break does not stop the counters at once: they run
        // for the whole stop window first; a further break
        // before the halt simply restarts the window.
        // counters run on after break
        if (break_event && !s.halted) begin
            next_s.stopping = 1'b1;
            next_s.stop_cnt = 17'h00000;
        end else if (s.stopping) begin
            if (s.stop_cnt >= 17'(STOP_COUNT - 1)) begin
                next_s.halted = 1'b1;
                next_s.stopping = 1'b0;
            end else begin
                next_s.stop_cnt = s.stop_cnt + 17'h00001;
            end
        end

        // a start copies the latches to the pins in one edge;
        // between starts the pins never follow the latches,
        // so console writes stay invisible until then.
        // console values reach pins here
        if (exec_start) begin
            next_s.sfr[SLOT_PORT3] = next_s.sfr[SLOT_PORT3] | PORT3_RSV_MASK;
            next_s.port1_pins = next_s.sfr[SLOT_PORT1];
            next_s.port3_pins = next_s.sfr[SLOT_PORT3] | PORT3_RSV_MASK;
            next_s.halted = 1'b0;
            next_s.stopping = 1'b0;
        end

        // the divider runs on while halted, so a break does
        // not disturb the tick phase.
        // machine-cycle tick; divider keeps counters off the fast clock
        if (s.tick_cnt >= 8'(TICK_COUNT - 1)) begin
            next_s.tick_cnt = 8'h00;
            tick = !s.halted;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 8'h01;
        end

        // counters sum from next_s so that a bus write in the
        // same cycle is counted on from, not lost.
        // run bits count, overflow sets flag
        c0 = {1'b0, next_s.sfr[SLOT_C0_HIGH], next_s.sfr[SLOT_C0_LOW]};
        c1 = {1'b0, next_s.sfr[SLOT_C1_HIGH], next_s.sfr[SLOT_C1_LOW]};
        if (tick && s.sfr[SLOT_CTRL][CTRL_RUN0]) begin
            c0 = c0 + 17'h00001;
            {next_s.sfr[SLOT_C0_HIGH], next_s.sfr[SLOT_C0_LOW]} = c0[15:0];
            // set after the bus write so the flag wins over a clear
            if (c0[16]) begin
                next_s.sfr[SLOT_CTRL][CTRL_OVF0] = 1'b1;
            end
        end
        if (tick && s.sfr[SLOT_CTRL][CTRL_RUN1]) begin
            c1 = c1 + 17'h00001;
            {next_s.sfr[SLOT_C1_HIGH], next_s.sfr[SLOT_C1_LOW]} = c1[15:0];
            if (c1[16]) begin
                next_s.sfr[SLOT_CTRL][CTRL_OVF1] = 1'b1;
            end
        end
    end

    // the ram itself has no reset; only the control state does
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.st <= ST_IDLE;
            s.sfr <= {SFR_COUNT{SFR_RESET}};
            s.sfr[SLOT_PUSH_PTR] <= PUSH_PTR_RESET;
            s.port1_pins <= 8'h00;
            s.port3_pins <= PORT3_RSV_MASK;
            s.tick_cnt <= 8'h00;
            s.stop_cnt <= 17'h00000;
            s.stopping <= 1'b0;
            s.halted <= 1'b0;
            s.err <= 1'b0;
            s.is_bit <= 1'b0;
            s.bit_pos <= 3'h0;
            s.bit_val <= 1'b0;
            s.rdata <= 32'h00000000;
        end else begin
            s <= next_s;
        end
    end

    // data outputs come straight from the state register, so
    // no bus input reaches them through logic; only the
    // handshake outputs decode the state.
    // outputs; the bus sees ready only in the done state
    assign prdata = s.rdata;
    assign pready = (s.st == ST_DONE);
    assign pslverr = (s.st == ST_DONE) && s.err;
    assign push_ready = (s.st == ST_IDLE);
    assign timers_halted = s.halted;
    assign port1_pins = s.port1_pins;
    assign port3_pins = s.port3_pins;
    assign view.ext_pointer = {s.sfr[SLOT_EXT_HIGH], s.sfr[SLOT_EXT_LOW]};
    assign view.counter_zero_value = {s.sfr[SLOT_C0_HIGH],
                                      s.sfr[SLOT_C0_LOW]};
    assign view.counter_one_value = {s.sfr[SLOT_C1_HIGH],
                                     s.sfr[SLOT_C1_LOW]};
    assign view.push_pointer = s.sfr[SLOT_PUSH_PTR];
    assign view.bank_base = {2'b00,
                             s.sfr[SLOT_FLAGS][FLAGS_BANK_LSB+1],
                             s.sfr[SLOT_FLAGS][FLAGS_BANK_LSB], 3'b000};
endmodule : orsm_top

// ===== verification/orsm_top_monitor.sv
// Purpose: port checks for the ram and register map
// Assumes: sees only the top ports, bound from the bench
// Notes:   halt window follows the bound stop count
`timescale 1ns/10ps
module orsm_top_monitor
    import orsm_pkg::*;
#(
    parameter int STOP_COUNT = 20,
    parameter int TICK_COUNT = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // core and kit side
    input wire logic push_valid,
    input wire logic [7:0] push_data,
    input wire logic push_ready,
    input wire logic exec_start,
    input wire logic break_event,
    input wire logic timers_halted,
    input wire logic [7:0] port1_pins,
    input wire logic [7:0] port3_pins,
    input wire orsm_view_t view
);
    localparam int HALT_MAX = STOP_COUNT + 8;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // steps of a push and of a break
    sequence s_push;
        push_valid && push_ready;
    endsequence
    sequence s_brk;
        break_event && !timers_halted && !exec_start;
    endsequence
    ptr_reset_a: assert property (
        $rose(presetn) |-> view.push_pointer == PUSH_PTR_RESET)
        else $error("push pointer wrong after reset");
    push_step_a: assert property (
        s_push |=> view.push_pointer == $past(view.push_pointer) + 8'h01)
        else $error("push pointer did not step by one");
    ptr_hold_a: assert property (
        !push_valid && !(psel && pwrite) |=> $stable(view.push_pointer))
        else $error("push pointer moved without a cause");
    port3_rsv_a: assert property (
        (port3_pins & PORT3_RSV_MASK) == PORT3_RSV_MASK)
        else $error("reserved port3 pins not high");
    pins_hold_a: assert property (
        !exec_start && !$past(exec_start) |->
        $stable(port1_pins) && $stable(port3_pins))
        else $error("port pins changed outside a start");
    halt_delay_a: assert property (
        s_brk |=> (!timers_halted) [*8] ##[1:HALT_MAX] timers_halted)
        else $error("counter halt timing wrong");
    unhalt_a: assert property (
        exec_start |-> ##[1:2] !timers_halted)
        else $error("halt not cleared by a start");
    no_err_a: assert property (
        pready && !paddr[11] |-> !pslverr)
        else $error("error on ram, sfr or bit space");
    far_err_a: assert property (
        pready && paddr[11:2] > 10'h202 |-> pslverr)
        else $error("unmapped access not refused");
    bit_lsb_a: assert property (
        pready && !pwrite && paddr[11:10] == 2'b01 |-> prdata[31:1] == 0)
        else $error("bit read wider than one bit");
endmodule : orsm_top_monitor

// ===== verification/orsm_core_model.sv
// Purpose: processor core stand-in, pushes and kit pulses
// Assumes: a push is taken at an edge with valid and ready
// Notes:   released data shows the inverse of the last byte
`timescale 1ns/10ps
module orsm_core_model (
    // clock
    input wire logic pclk,
    // push handshake
    input wire logic push_ready,
    output logic push_valid,
    output logic [7:0] push_data,
    // kit pulses
    output logic exec_start,
    output logic break_event
);
    logic stuck;
    initial begin
        stuck = 1'b0;
        push_valid = 1'b0;
        push_data = 8'h00;
        exec_start = 1'b0;
        break_event = 1'b0;
    end
    // back to back pushes, stack kept low
    task automatic push2(input logic [15:0] d);
        logic r;
        push_valid <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            push_data <= d[8*k +: 8];
            r = 1'b0;
            for (int n = 0; n < 50 && !r; n++) begin
                @(negedge pclk);
                r = (push_ready === 1'b1);
                @(posedge pclk);
            end
            if (!r) stuck = 1'b1;
        end
        push_valid <= 1'b0;
        push_data <= ~d[15:8];
        @(posedge pclk);
    endtask : push2
    // one-cycle pulse: a break if brk, else a start
    task automatic pulse(input logic brk);
        if (brk) break_event <= 1'b1;
        else exec_start <= 1'b1;
        @(posedge pclk);
        break_event <= 1'b0;
        exec_start <= 1'b0;
    endtask : pulse
endmodule : orsm_core_model

// ===== verification/orsm_top_bench.sv
// Purpose: self-checking bench for the ram and register map
// Assumes: apb master here, core pushes from the model
// Notes:   short stop and tick counts keep the run brief
`timescale 1ns/10ps
module orsm_top_bench
    import orsm_pkg::*;
;
    localparam int STOP = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic push_valid, push_ready, exec_start, break_event, timers_halted;
    logic [7:0] push_data, port1_pins, port3_pins;
    orsm_view_t view;
    int n_fail, samples_checked;
    logic [33:0] notes[$];
    logic [33:0] nt;
    // clock
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;
    orsm_top #(.STOP_COUNT(STOP), .TICK_COUNT(2)) dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .push_valid, .push_data, .push_ready, .exec_start,
        .break_event, .timers_halted, .port1_pins, .port3_pins, .view);
    orsm_core_model core (.pclk, .push_ready, .push_valid, .push_data,
        .exec_start, .break_event);
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude;
        $display("checked %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // one transfer; waits for pready, bounded
    task automatic apb(input logic wr, input logic [9:0] idx,
            input logic [31:0] d, input logic err);
        logic r;
        notes.push_back({~wr, err, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        r = 1'b0;
        for (int n = 0; n < 50 && !r; n++) begin
            @(negedge pclk);
            r = (pready === 1'b1);
            @(posedge pclk);
        end
        if (!r) begin
            n_fail++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
        @(posedge pclk);
    endtask : apb
    // watcher: an answered transfer takes the oldest note
    always @(negedge pclk) begin
        if (psel && penable && pready) begin
            nt = notes.pop_front();
            check("pslverr", 32'(pslverr), 32'(nt[32]));
            if (nt[33]) check("prdata", prdata, nt[31:0]);
        end
    end
    initial begin
        logic [7:0] a, d;
        logic [7:0] v [SFR_COUNT];
        logic [15:0] c;
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_fail = 0;
        samples_checked = 0;
        void'($urandom(92));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check("ptr", 32'(view.push_pointer), 32'h07);
        check("p3", 32'(port3_pins), 32'hc4);
        @(posedge pclk);
        apb(0, 10'h081, 32'h07, 0);
        core.push2(16'hc33c);
        apb(0, 10'h008, 32'h3c, 0);
        apb(0, 10'h009, 32'hc3, 0);
        $display("reset and push done");
        // ram corners and random places
        for (int k = 0; k < 6; k++) begin
            a = k == 0 ? 8'h00 : k == 1 ? 8'h1f : k == 2 ? 8'h7f
                : 8'($urandom_range(48, 126));
            d = 8'($urandom);
            apb(1, {2'b00, a}, {24'h0, d}, 0);
            apb(0, {2'b00, a}, {24'h0, d}, 0);
        end
        // whole register table; run bits kept clear so counts hold
        for (int k = 0; k < SFR_COUNT; k++) begin
            d = 8'($urandom);
            v[k] = k == 1 ? d & 8'h3f : k == 4 ? d & 8'h0f
                : k == 15 ? d | 8'hc4 : d;
            apb(1, {2'b00, SFR_ADDR[k]}, {24'h0, v[k]}, 0);
        end
        for (int k = 0; k < SFR_COUNT; k++)
            apb(0, {2'b00, SFR_ADDR[k]}, {24'h0, v[k]}, 0);
        @(negedge pclk);
        check("bank", 32'(view.bank_base), 32'({v[17][4:3], 3'b0}));
        check("ext", 32'(view.ext_pointer), {v[3], v[2]});
        check("cnt0", 32'(view.counter_zero_value), {v[8], v[6]});
        @(posedge pclk);
        apb(1, 10'h084, 32'h5a, 0);
        apb(0, 10'h084, 32'h0, 0);
        apb(0, 10'h1f8, 32'h0, 0);
        apb(1, 10'h3ff, 32'h1, 1);
        d = 8'($urandom);
        apb(1, 10'h200, {16'h0, d, ~d}, 0);
        apb(0, 10'h082, {24'h0, ~d}, 0);
        apb(0, 10'h083, {24'h0, d}, 0);
        apb(1, 10'h202, 32'h1234, 0);
        apb(0, 10'h08d, 32'h12, 0);
        apb(0, 10'h202, 32'h1234, 0);
        $display("map and wide views done");
        // each bit of 88 and 98 alone, run bits skipped, then a clear by an even value
        for (int k = 0; k < 16; k++) begin
            a = k < 8 ? 8'h88 + 8'(k) : 8'h90 + 8'(k);
            if (a == 8'h8c || a == 8'h8e) continue;
            apb(1, {2'b00, a[7:3], 3'b000}, 32'h0, 0);
            apb(1, {2'b01, a}, 32'hff, 0);
            apb(0, {2'b00, a[7:3], 3'b000}, 32'h1 << a[2:0], 0);
            apb(1, {2'b01, a}, 32'hfe, 0);
            apb(0, {2'b01, a}, 32'h0, 0);
        end
        apb(1, 10'h02f, 32'h0, 0);
        apb(1, 10'h17f, 32'h3, 0);
        apb(0, 10'h02f, 32'h80, 0);
        apb(0, 10'h17f, 32'h1, 0);
        $display("bit space done");
        apb(1, 10'h090, 32'h5a, 0);
        apb(1, 10'h0b0, 32'h01, 0);
        apb(1, 10'h18c, 32'h1, 0);
        apb(0, 10'h088, 32'h10, 0);
        core.pulse(1);
        for (int n = 0; n < STOP + 20 && timers_halted !== 1'b1; n++)
            @(negedge pclk);
        check("halt", 32'(timers_halted), 32'h1);
        check("p1 held", 32'(port1_pins), 32'h0);
        c = view.counter_zero_value;
        repeat (8) @(negedge pclk);
        check("frozen", 32'(view.counter_zero_value), 32'(c));
        check("ran", 32'(c !== {v[8], v[6]}), 32'h1);
        @(posedge pclk);
        core.pulse(0);
        repeat (2) @(negedge pclk);
        check("p1", 32'(port1_pins), 32'h5a);
        check("p3", 32'(port3_pins), 32'hc5);
        check("unhalt", 32'(timers_halted), 32'h0);
        @(posedge pclk);
        apb(0, 10'h0b0, 32'hc5, 0);
        check("push hang", 32'(core.stuck), 32'h0);
        $display("ports and break done");
        conclude();
    end
endmodule : orsm_top_bench
bind orsm_top orsm_top_monitor #(.STOP_COUNT(STOP_COUNT),
    .TICK_COUNT(TICK_COUNT)) mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .push_valid,
    .push_data, .push_ready, .exec_start, .break_event, .timers_halted,
    .port1_pins, .port3_pins, .view);
